// ===== core/prc_pkg.sv
package prc_pkg;
    // sample and result widths
    localparam int ADC_W         = 10;
    localparam int PIX_W         = 8;
    localparam int ADDR_W        = 18;
    localparam int CODE_W        = 2;
    // code bit positions
    localparam int HI_BIT        = 1;
    localparam int LO_BIT        = 0;
    // sector geometry, half a sensor
    localparam int SECT_COLS     = 640;
    localparam int SECT_ROWS     = 320;
    // window radius for the 3x3 neighbourhood
    localparam int WIN_R         = 1;
    // ladder board population
    localparam int N_CARDS       = 5;
    localparam int SENS_PER_CARD = 2;
    // timing: system clock and pixel period
    localparam int CLK_NS        = 10;
    localparam int PIX_NS        = 20;
    localparam int PIX_DIV       = (PIX_NS + CLK_NS - 1) / CLK_NS;
    // pin synchroniser depth
    localparam int SYNC_N        = 3;
    // saturation ceiling of a result
    localparam logic [PIX_W-1:0] CLIP_MAX = 8'hff;

    // test-access port lines towards the sensors
    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
    } prc_jtag_s;

    // one word of the cluster stream
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
    } prc_clu_s;
endpackage

// ===== core/prc_readout.sv
`timescale 1ns/1ps
module prc_readout #(
    parameter int COLS   = prc_pkg::SECT_COLS,
    parameter int ROWS   = prc_pkg::SECT_ROWS,
    parameter int N_SENS = prc_pkg::N_CARDS * prc_pkg::SENS_PER_CARD
) (
    input  wire logic                        i_mclk,
    input  wire logic                        i_rst_n,
    input  wire logic [prc_pkg::ADC_W-1:0]   i_adc_data,
    output logic                             o_adc_clk,
    output logic [N_SENS-1:0]                o_sns_clk,
    input  prc_pkg::prc_jtag_s               i_cfg_jtag,
    output prc_pkg::prc_jtag_s               o_sns_jtag,
    input  wire logic                        i_sns_tdo,
    output logic                             o_cfg_tdo,
    output logic [prc_pkg::ADDR_W-1:0]       o_mem_addr,
    output logic                             o_mem_rd,
    output logic                             o_mem_we,
    output logic [prc_pkg::ADC_W-1:0]        o_mem_wdata,
    input  wire logic [prc_pkg::ADC_W-1:0]   i_mem_rdata,
    input  wire logic [prc_pkg::PIX_W-1:0]   i_thr_hi,
    input  wire logic [prc_pkg::PIX_W-1:0]   i_thr_lo,
    input  wire logic                        i_trigger,
    output logic                             o_capture,
    output logic                             o_link_valid,
    output prc_pkg::prc_clu_s                o_link_data,
    input  wire logic                        i_link_ready,
    output logic                             o_overflow
);
    localparam int CW   = $clog2(COLS);
    localparam int RW   = $clog2(ROWS);
    localparam int BW   = $clog2(2 * COLS);
    localparam int PW   = $clog2(prc_pkg::PIX_DIV + 1);
    localparam int SR_N = 2 * COLS + 3;
    localparam int CEN  = COLS + prc_pkg::WIN_R;
    localparam int SY_W = $bits(prc_pkg::prc_jtag_s) + 2;
    localparam int TDO  = SY_W - 2;
    localparam int TRG  = SY_W - 1;
    localparam logic [CW-1:0] COL_LAST = CW'(COLS - 1);
    localparam logic [RW-1:0] ROW_LAST = RW'(ROWS - 1);
    localparam logic [PW-1:0] PH_LAST  = PW'(prc_pkg::PIX_DIV - 1);
    localparam logic [CW-1:0] EDGE_C   = CW'(2 * prc_pkg::WIN_R);
    localparam logic [RW-1:0] EDGE_R   = RW'(2 * prc_pkg::WIN_R);

    // saturating difference, negatives suppressed to zero
    function automatic logic [prc_pkg::PIX_W-1:0] sat_diff(
        input logic [prc_pkg::ADC_W-1:0] cur,
        input logic [prc_pkg::ADC_W-1:0] prev
    );
        logic [prc_pkg::ADC_W:0] d;
        d = {1'h0, cur} - {1'h0, prev};
        if (d[prc_pkg::ADC_W])
            sat_diff = '0;
        else if (d[prc_pkg::ADC_W-1:0] > {2'h0, prc_pkg::CLIP_MAX})
            sat_diff = prc_pkg::CLIP_MAX;
        else
            sat_diff = d[prc_pkg::PIX_W-1:0];
    endfunction

    // line buffer slot of a column in a bank
    function automatic logic [BW-1:0] slot(
        input logic          bank,
        input logic [CW-1:0] col
    );
        slot = bank ? BW'(COLS) + BW'(col) : BW'(col);
    endfunction

    logic [SY_W-1:0]            s1_q, s2_q, s3_q; // pin synchroniser
    logic [SY_W-1:0]            sy_q;             // agreed pin levels
    logic                       trg_prev_q;       // trigger edge memory
    logic [PW-1:0]              ph_q;             // pixel phase
    logic [CW-1:0]              sc_q;             // sensor column
    logic [RW-1:0]              srow_q;           // sensor row
    logic [prc_pkg::ADDR_W-1:0] idx_q;            // readout order index
    logic [prc_pkg::ADC_W-1:0]  adc_q;            // captured sample
    logic [CW-1:0]              pc_q;             // column of sample
    logic [RW-1:0]              prow_q;           // row of sample
    logic [prc_pkg::PIX_W-1:0]  pix_q;            // subtracted result
    logic                       pv_q;             // result valid
    logic [prc_pkg::PIX_W-1:0]  lbuf [2*COLS];    // reorder line banks
    logic                       primed_q;         // one line stored
    logic [prc_pkg::PIX_W-1:0]  rb_q;             // raster pixel
    logic                       rv_q;             // raster valid
    logic [CW-1:0]              rc_q;             // raster column
    logic [RW-1:0]              rr_q;             // raster row
    logic [prc_pkg::CODE_W-1:0] code_q;           // threshold code
    logic                       cv_q;             // code valid
    logic [CW-1:0]              cc_q;
    logic [RW-1:0]              cr_q;
    logic [SR_N-1:0][prc_pkg::CODE_W-1:0] sh_q;   // code shift register
    logic                       wv_q;             // window fresh
    logic [CW-1:0]              wc_q;             // newest column
    logic [RW-1:0]              wr_q;             // newest row
    logic                       arm_q;            // trigger pending
    logic                       hit_d, hit_q;     // cluster found
    prc_pkg::prc_clu_s          clu_d, clu_q;     // centre address
    logic                       sv_q;             // spare slot full
    prc_pkg::prc_clu_s          sp_q;             // spare slot word
    logic                       push, pop;
    logic                       nb_lo, interior, frame0;

    // pins pass three flops; a level counts once the last two agree
    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
        begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            sy_q <= '0;
        end
        else
        begin
            s1_q <= {i_trigger, i_sns_tdo, i_cfg_jtag};
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q)
                sy_q <= s3_q;
        end
    end

    // config port pass-through
    // host test-access lines re-timed towards the sensors, data back
    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
        begin
            o_sns_jtag <= '0;
            o_cfg_tdo  <= 1'h0;
        end
        else
        begin
            o_sns_jtag <= sy_q[TDO-1:0];
            o_cfg_tdo  <= sy_q[TDO];
        end
    end

    // free running pixel clock
    // phase counter never stops; the sensors expect an endless clock
    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
            ph_q <= '0;
        else if (ph_q == PH_LAST)
            ph_q <= '0;
        else
            ph_q <= ph_q + PW'(1);
    end

    // per-sensor clock drivers
    // one flop per sensor so each line is driven from its own register
    genvar gs;
    generate
        for (gs = 0; gs < N_SENS; gs++)
        begin : g_sclk
            always_ff @(posedge i_mclk)
            begin
                if (!i_rst_n)
                    o_sns_clk[gs] <= 1'h0;
                else
                    o_sns_clk[gs] <= (ph_q == PH_LAST);
            end
        end
    endgenerate

    // converter clock shares the pixel clock edge
    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
            o_adc_clk <= 1'h0;
        else
            o_adc_clk <= (ph_q == PH_LAST);
    end

    // one conversion per pixel
    // sample, fetch stored value, then write the new one back
    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
        begin
            adc_q       <= '0;
            o_mem_addr  <= '0;
            o_mem_rd    <= 1'h0;
            o_mem_we    <= 1'h0;
            o_mem_wdata <= '0;
            pc_q        <= '0;
            prow_q      <= '0;
        end
        else
        begin
            o_mem_rd <= (ph_q == '0);
            o_mem_we <= o_mem_rd;
            if (ph_q == '0)
            begin
                adc_q      <= i_adc_data;
                o_mem_addr <= idx_q;
                pc_q       <= sc_q;
                prow_q     <= srow_q;
            end
            if (o_mem_rd)
                o_mem_wdata <= adc_q;
        end
    end

    // readout order counters, wrap every frame
    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
        begin
            sc_q   <= '0;
            srow_q <= '0;
            idx_q  <= '0;
        end
        else if (ph_q == '0)
        begin
            if (sc_q == COL_LAST)
            begin
                sc_q <= '0;
                if (srow_q == ROW_LAST)
                begin
                    srow_q <= '0;
                    idx_q  <= '0;
                end
                else
                begin
                    srow_q <= srow_q + RW'(1);
                    idx_q  <= idx_q + prc_pkg::ADDR_W'(1);
                end
            end
            else
            begin
                sc_q  <= sc_q + CW'(1);
                idx_q <= idx_q + prc_pkg::ADDR_W'(1);
            end
        end
    end

    // synchronous subtraction stage
    // memory answers within the read cycle, same pixel period
    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
        begin
            pix_q <= '0;
            pv_q  <= 1'h0;
        end
        else
        begin
            pv_q <= o_mem_rd;
            if (o_mem_rd)
                pix_q <= sat_diff(adc_q, i_mem_rdata);
        end
    end

    // line reorder to raster
    // odd lines arrive reversed; written mirrored, read one line later
    always_ff @(posedge i_mclk)
    begin
        if (pv_q)
            lbuf[slot(prow_q[0], prow_q[0] ? COL_LAST - pc_q : pc_q)]
                <= pix_q;
    end

    // raster read of the previous line, plus its position
    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
        begin
            primed_q <= 1'h0;
            rb_q     <= '0;
            rv_q     <= 1'h0;
            rc_q     <= '0;
            rr_q     <= '0;
        end
        else
        begin
            // nothing valid until a whole line sits in a bank
            if (pv_q && pc_q == COL_LAST)
                primed_q <= 1'h1;
            rv_q <= pv_q && primed_q;
            if (pv_q)
            begin
                rb_q <= lbuf[slot(~prow_q[0], pc_q)];
                rc_q <= pc_q;
                rr_q <= (prow_q == '0) ? ROW_LAST : prow_q - RW'(1);
            end
        end
    end

    // dual threshold code
    // same two settings for every pixel of the sector
    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
        begin
            code_q <= '0;
            cv_q   <= 1'h0;
            cc_q   <= '0;
            cr_q   <= '0;
        end
        else
        begin
            cv_q <= rv_q;
            if (rv_q)
            begin
                code_q[prc_pkg::HI_BIT] <= rb_q > i_thr_hi;
                code_q[prc_pkg::LO_BIT] <= rb_q > i_thr_lo;
                cc_q <= rc_q;
                cr_q <= rr_q;
            end
        end
    end

    // two lines plus three codes
    // index 0 holds the newest code, CEN the window centre
    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
        begin
            sh_q <= '0;
            wv_q <= 1'h0;
            wc_q <= '0;
            wr_q <= '0;
        end
        else
        begin
            wv_q <= cv_q;
            if (cv_q)
            begin
                sh_q <= {sh_q[SR_N-2:0], code_q};
                wc_q <= cc_q;
                wr_q <= cr_q;
            end
        end
    end

    // window decision: centre high, any neighbour low, inside sector
    always_comb
    begin
        nb_lo = 1'h0;
        for (int r = 0; r <= 2 * prc_pkg::WIN_R; r++)
            for (int c = 0; c <= 2 * prc_pkg::WIN_R; c++)
                if (r * COLS + c != CEN)
                    nb_lo = nb_lo | sh_q[r * COLS + c][prc_pkg::LO_BIT];
        interior = (wr_q >= EDGE_R) && (wc_q >= EDGE_C);
        hit_d = wv_q && interior && sh_q[CEN][prc_pkg::HI_BIT] && nb_lo;
        clu_d.addr = prc_pkg::ADDR_W'((wr_q - RW'(prc_pkg::WIN_R)) * COLS
                   + (wc_q - CW'(prc_pkg::WIN_R)));
        frame0 = wv_q && wr_q == '0 && wc_q == '0;
    end

    // trigger saves next frame
    // arming survives a start in the same cycle: the set wins
    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
        begin
            trg_prev_q <= 1'h0;
            arm_q      <= 1'h0;
            o_capture  <= 1'h0;
        end
        else
        begin
            trg_prev_q <= sy_q[TRG];
            arm_q <= (sy_q[TRG] && !trg_prev_q) || (arm_q && !frame0);
            if (frame0)
                o_capture <= arm_q;
        end
    end

    // pipelined finder output
    // finder never stalls; a hit with both slots busy is counted lost
    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
        begin
            hit_q      <= 1'h0;
            clu_q      <= '0;
            o_overflow <= 1'h0;
        end
        else
        begin
            hit_q <= hit_d && o_capture;
            clu_q <= clu_d;
            // lost only when both slots stay busy this cycle
            if (hit_q && !push)
                o_overflow <= 1'h1;
        end
    end

    // a pop frees the spare in the same cycle, so the hit still fits
    assign push = hit_q && (!sv_q || pop);
    assign pop  = o_link_valid && i_link_ready;

    // two-entry link buffer
    // head register drives the link, spare catches a stalled word
    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
        begin
            o_link_valid <= 1'h0;
            o_link_data  <= '0;
            sv_q         <= 1'h0;
            sp_q         <= '0;
        end
        else if (!o_link_valid || pop)
        begin
            if (sv_q)
            begin
                o_link_valid <= 1'h1;
                o_link_data  <= sp_q;
                sv_q         <= push;
                sp_q         <= clu_q;
            end
            else
            begin
                o_link_valid <= push;
                o_link_data  <= clu_q;
            end
        end
        else if (push)
        begin
            sv_q <= 1'h1;
            sp_q <= clu_q;
        end
    end

    pix_clk_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        o_sns_clk[0] |=> !o_sns_clk[0] ##1 o_sns_clk[0])
        else $error("pixel clock not at divided rate");
    mem_rw_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        o_mem_rd |=> o_mem_we && $stable(o_mem_addr))
        else $error("stored sample not written back");
    pix_rate_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        pv_q |=> !pv_q ##1 pv_q)
        else $error("result rate differs from pixel rate");
    zero_sup_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        pv_q && $past(adc_q) < $past(i_mem_rdata) |-> pix_q == '0)
        else $error("negative difference not suppressed");
    clip_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        pv_q && {1'h0, $past(adc_q)} > {1'h0, $past(i_mem_rdata)} + 11'h0ff
        |-> pix_q == prc_pkg::CLIP_MAX)
        else $error("large difference not clipped");
    code_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        rv_q |=> code_q[prc_pkg::HI_BIT] == ($past(rb_q) > i_thr_hi))
        else $error("high code bit wrong");
    hit_cen_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        hit_q |-> $past(interior) && $past(sh_q[CEN][prc_pkg::HI_BIT]))
        else $error("hit without interior high centre");
    // saving only within a captured frame
    cap_only_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        hit_q |-> $past(o_capture))
        else $error("cluster saved outside capture");
    link_hold_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        o_link_valid && !i_link_ready
        |=> o_link_valid && $stable(o_link_data))
        else $error("link word dropped during stall");
endmodule // prc_readout

// ===== tb/prc_partner.sv
`timescale 1ns/1ps
// far side: sensor source, sample memory, link sink
module prc_partner #(
    parameter int NPIX = 48
) (
    input  wire logic                       i_mclk,
    input  wire logic                       i_rst_n,
    input  wire logic                       i_adc_clk,
    input  wire logic [prc_pkg::ADDR_W-1:0] i_addr,
    input  wire logic                       i_rd,
    input  wire logic                       i_we,
    input  wire logic [prc_pkg::ADC_W-1:0]  i_wdata,
    input  wire logic                       i_stall,
    input  wire logic                       i_hot,
    output logic [prc_pkg::ADC_W-1:0]       o_rdata,
    output logic [prc_pkg::ADC_W-1:0]       o_sample,
    output logic                            o_ready
);
    logic [9:0]  mem [NPIX]; // stored sample per pixel
    logic [15:0] cnt_q;      // samples shifted so far
    logic [1:0]  cyc_q;      // sink stall phase
    logic        rd_q;       // read answer still owed
    int          pix_n;      // pixel now on the output

    // frame 1 carries the test image, others the baseline
    function automatic logic [9:0] pat(input int f, input int i);
        if (f != 1)
            return 10'h12c;
        case (i)
            19, 31: return 10'h1f4; // strong; 19 a hit, 31 lands on the sector edge column
            20, 30: return 10'h14a; // weak neighbours
            34:     return 10'h1cc; // strong, diagonal to weak 30
            10:     return 10'h0fa; // below stored value
            default: return 10'h12c;
        endcase
    endfunction

    initial
    begin
        cyc_q = 2'h0;
        rd_q = 1'b0;
        foreach (mem[i])
            mem[i] = 10'h000;
    end

    // one pixel per converter clock, never paused
    always @(posedge i_mclk)
    begin
        if (!i_rst_n)
            cnt_q <= 16'h0000;
        else if (i_adc_clk)
            cnt_q <= cnt_q + 16'h0001;
    end
    // a clock shifts the next pixel out within its own cycle
    assign pix_n = int'(cnt_q) + int'(i_adc_clk);
    // one sector stream; the twin sector feeds its own copy
    assign o_sample = i_hot ? 10'h3ff
                    : pat(pix_n / NPIX, pix_n % NPIX);

    // memory write and sink pacing
    always @(posedge i_mclk)
    begin
        rd_q <= i_rd;
        cyc_q <= cyc_q + 2'h1;
        if (i_we)
            mem[i_addr] <= i_wdata;
    end
    // idle bus shows the inverse, never stale data
    assign o_rdata = (i_rd || rd_q) ? mem[i_addr] : ~mem[i_addr];
    // sink stalls one cycle in four, or always
    assign o_ready = !i_stall && (cyc_q != 2'h3);
endmodule // prc_partner

// ===== tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    localparam int COLS = 8;
    localparam int ROWS = 6;
    localparam int N_SENS = 10;
    logic                 i_mclk;
    logic                 i_rst_n;
    logic [9:0]           i_adc_data;
    logic                 o_adc_clk;
    logic [N_SENS-1:0]    o_sns_clk;
    prc_pkg::prc_jtag_s   i_cfg_jtag;
    prc_pkg::prc_jtag_s   o_sns_jtag;
    logic                 i_sns_tdo;
    logic                 o_cfg_tdo;
    logic [17:0]          o_mem_addr;
    logic                 o_mem_rd;
    logic                 o_mem_we;
    logic [9:0]           o_mem_wdata;
    logic [9:0]           i_mem_rdata;
    logic [7:0]           i_thr_hi;
    logic [7:0]           i_thr_lo;
    logic                 i_trigger;
    logic                 o_capture;
    logic                 o_link_valid;
    prc_pkg::prc_clu_s    o_link_data;
    logic                 i_link_ready;
    logic                 o_overflow;
    logic                 stall;   // sink refuses all words
    logic                 hot;     // every sample saturates
    logic                 mon_on;  // expectation tracking on
    logic                 seen;    // a frame is partly known
    logic [7:0]           img [COLS*ROWS]; // raster results
    logic [9:0]           shd [COLS*ROWS]; // shadow memory
    logic [17:0]          got_q[$];
    logic [17:0]          exp_q[$];
    int                   n_errors, n_checks, nfr, a, r, c;

    prc_readout #(.COLS(COLS), .ROWS(ROWS), .N_SENS(N_SENS)) dut (
        .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_adc_data(i_adc_data),
        .o_adc_clk(o_adc_clk), .o_sns_clk(o_sns_clk),
        .i_cfg_jtag(i_cfg_jtag), .o_sns_jtag(o_sns_jtag),
        .i_sns_tdo(i_sns_tdo), .o_cfg_tdo(o_cfg_tdo),
        .o_mem_addr(o_mem_addr), .o_mem_rd(o_mem_rd),
        .o_mem_we(o_mem_we), .o_mem_wdata(o_mem_wdata),
        .i_mem_rdata(i_mem_rdata), .i_thr_hi(i_thr_hi),
        .i_thr_lo(i_thr_lo), .i_trigger(i_trigger),
        .o_capture(o_capture), .o_link_valid(o_link_valid),
        .o_link_data(o_link_data), .i_link_ready(i_link_ready),
        .o_overflow(o_overflow));

    prc_partner #(.NPIX(COLS*ROWS)) far (
        .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_adc_clk(o_adc_clk),
        .i_addr(o_mem_addr), .i_rd(o_mem_rd), .i_we(o_mem_we),
        .i_wdata(o_mem_wdata), .i_stall(stall), .i_hot(hot),
        .o_rdata(i_mem_rdata), .o_sample(i_adc_data),
        .o_ready(i_link_ready));

    initial
    begin
        i_mclk = 1'b0;
        forever
            #5 i_mclk = ~i_mclk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t: got %0h want %0h", $time, got, exp);
        end
    endtask

    task automatic report_and_stop();
        if (n_errors == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // a wait that ran out ends the run
    task automatic guard(input logic ok);
        if (!ok)
        begin
            n_errors++;
            report_and_stop();
        end
    endtask

    // clamp below zero and above eight bits
    function automatic logic [7:0] sat(input logic [9:0] cur, prv);
        int d;
        d = int'(cur) - int'(prv);
        return d < 0 ? 8'h00 : (d > 255 ? 8'hff : 8'(d));
    endfunction

    // centres off the sector edge with a strong core
    task automatic find_hits();
        logic nb;
        for (int r2 = 1; r2 < ROWS - 1; r2++)
            for (int c2 = 1; c2 < COLS - 1; c2++)
            begin
                nb = 1'b0;
                for (int dr = -1; dr < 2; dr++)
                    for (int dc = -1; dc < 2; dc++)
                        if ((dr | dc) != 0
                            && img[(r2 + dr) * COLS + c2 + dc] > i_thr_lo)
                            nb = 1'b1;
                if (img[r2 * COLS + c2] > i_thr_hi && nb)
                    exp_q.push_back(18'(r2 * COLS + c2));
            end
    endtask

    // watch memory writes and accepted words off the edge
    always @(negedge i_mclk)
    begin
        if (i_rst_n && mon_on && o_link_valid && i_link_ready)
            got_q.push_back(o_link_data.addr);
        if (i_rst_n && mon_on && o_mem_we)
        begin
            a = int'(o_mem_addr);
            if (a == 0 && seen)
            begin
                // only the two triggered frames reach the link
                if (nfr < 2)
                    find_hits();
                nfr++;
            end
            seen = 1'b1;
            r = a / COLS;
            // odd sensor rows arrive mirrored
            c = (r % 2 == 1) ? COLS - 1 - a % COLS : a % COLS;
            img[r * COLS + c] = sat(o_mem_wdata, shd[a]);
            shd[a] = o_mem_wdata;
        end
    end

    task automatic t_pins();
        logic [7:0] hi;
        hi = 8'h00;
        repeat (20)
        begin
            @(negedge i_mclk);
            hi = hi + 8'(o_adc_clk);
            chk(o_sns_clk, {N_SENS{o_adc_clk}}); // clocks agree
        end
        chk(hi, 8'h0a); // one sample per two cycles
        for (int k = 0; k < 2; k++)
        begin
            @(posedge i_mclk);
            i_cfg_jtag <= k ? 3'h2 : 3'h5;
            i_sns_tdo <= k ? 1'b0 : 1'b1;
            repeat (10) @(negedge i_mclk);
            chk(o_sns_jtag, k ? 3'h2 : 3'h5); // config lines
            chk(o_cfg_tdo, k ? 1'b0 : 1'b1); // return line
        end
    endtask

    task automatic t_trigger();
        int n;
        // first pulse lands before raster frame 0 opens
        @(posedge i_mclk);
        i_trigger <= 1'b1;
        repeat (4) @(posedge i_mclk);
        i_trigger <= 1'b0;
        for (n = 0; o_capture !== 1'b1 && n < 400; n++)
            @(negedge i_mclk);
        guard(n < 400);
        // second pulse inside the open frame re-arms the next one
        @(posedge i_mclk);
        i_trigger <= 1'b1;
        repeat (4) @(posedge i_mclk);
        i_trigger <= 1'b0;
        @(negedge i_mclk);
        // five open cycles already passed during the pulse
        for (n = 5; o_capture === 1'b1 && n < 400; n++)
            @(negedge i_mclk);
        chk(n, 2 * COLS * ROWS * prc_pkg::PIX_DIV); // two frames open
    endtask

    task automatic t_clusters();
        int n;
        for (n = 0; nfr < 4 && n < 2000; n++)
            @(negedge i_mclk);
        guard(n < 2000);
        repeat (40) @(negedge i_mclk);
        chk(exp_q.size() > 24, 1'b1); // saturated frame hits
        chk(got_q.size(), exp_q.size()); // every hit sent
        // order and value of each centre address
        for (int i = 0; i < got_q.size() && i < exp_q.size(); i++)
            chk(got_q[i], exp_q[i]); // centre address
    endtask

    task automatic t_overflow();
        int n;
        mon_on = 1'b0;
        @(posedge i_mclk);
        i_rst_n <= 1'b0;
        stall <= 1'b1;
        hot <= 1'b1;
        repeat (4) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        // capture must be open for hits to reach the stalled link
        @(posedge i_mclk);
        i_trigger <= 1'b1;
        repeat (4) @(posedge i_mclk);
        i_trigger <= 1'b0;
        for (n = 0; o_overflow !== 1'b1 && n < 400; n++)
            @(negedge i_mclk);
        guard(n < 400);
        chk(o_link_valid, 1'b1); // word held while refused
        @(posedge i_mclk);
        i_rst_n <= 1'b0;
        repeat (2) @(negedge i_mclk);
        chk(o_overflow, 1'b0); // cleared by reset
    endtask

    initial
    begin
        i_rst_n = 1'b0;
        i_cfg_jtag = 3'h0;
        i_sns_tdo = 1'b0;
        i_thr_hi = 8'h96;
        i_thr_lo = 8'h14;
        i_trigger = 1'b0;
        stall = 1'b0;
        hot = 1'b0;
        mon_on = 1'b1;
        seen = 1'b0;
        n_errors = 0;
        n_checks = 0;
        nfr = 0;
        repeat (16) @(negedge i_mclk);
        chk({o_link_valid, o_capture, o_overflow}, 3'h0); // quiet
        @(posedge i_mclk);
        i_rst_n <= 1'b1;
        t_trigger();
        t_pins();
        t_clusters();
        t_overflow();
        report_and_stop();
    end
endmodule // tb_top
